// [core/dsp_ctrl.sv]
`timescale 1ns/100ps
// Operation
// - Wait with both selects enters deep standby
// - Wait with only standby select: normal standby
// - Keep oscillators, reset, detector, clock on
// - Only USB resume detector stays on
// - Stop core, internal oscillators and PLL
// - Stop flash, peripherals, bus, port logic
// - First RAM kept, second RAM lost
// - Power-cut field gates RAM, USB, reset, detector
// - Deep standby exit is a dedicated reset
// - Large variant refuses entry on main/PLL
// - Wake latency depends on mode and clock
module dsp_ctrl
  import dsp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        wait_exec,
  input  wire logic [1:0]  core_clock_src,
  input  wire logic [1:0]  core_clock_div,
  input  wire logic        large_variant,
  input  wire logic [7:0]  wake_pin,
  output dsp_power_t       power,
  output logic             deep_standby_reset,
  output logic             irq
);

  // ****************************************************
  // State
  // ****************************************************
  logic [7:0]  standby_control_reg;
  logic [7:0]  deep_standby_control_reg;
  logic [7:0]  write_protect_reg;
  logic [7:0]  wake_edge_select_reg;
  logic [7:0]  wake_source_enable_reg;
  logic [7:0]  wake_source_flag_reg;
  logic [3:0]  irq_stat_reg;
  logic [3:0]  irq_mask_reg;
  dsp_state_t  state_reg;
  dsp_state_t  state_next;
  logic [11:0] lat_cnt_reg;
  logic [11:0] lat_cnt_next;
  logic [7:0]  wake_s1_reg;
  logic [7:0]  wake_s2_reg;
  logic [7:0]  wake_s3_reg;
  logic        large_s1_reg;
  logic        large_s2_reg;
  logic [5:0]  aw_addr_reg;
  logic        aw_have_reg;
  logic [7:0]  w_data_reg;
  logic        w_be_reg;
  logic        w_have_reg;
  dsp_power_t  power_next;

  // Wake-up cycle count from mode and prior core clock divider
  function automatic logic [11:0] lat_cycles(input logic deep,
                                             input logic [1:0] div);
    logic [11:0] base;
    base = deep ? LAT_DEEP_BASE : LAT_STBY_BASE;
    lat_cycles = base + (LAT_CLK_STEP << div);
  endfunction

  // ****************************************************
  // Bus decode
  // ****************************************************
  wire wr_fire     = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire rd_fire     = s_axi_arvalid && s_axi_arready;
  wire mode_unlock = write_protect_reg[UNLOCK_MODE_BIT];
  wire wr_stby     = wr_fire && w_be_reg && aw_addr_reg == ADDR_STBY_CTRL;
  wire wr_deep     = wr_fire && w_be_reg && aw_addr_reg == ADDR_DEEP_CTRL;
  wire wr_prot     = wr_fire && w_be_reg && aw_addr_reg == ADDR_PROTECT;
  wire wr_edge     = wr_fire && w_be_reg && aw_addr_reg == ADDR_WAKE_EDGE;
  wire wr_en       = wr_fire && w_be_reg && aw_addr_reg == ADDR_WAKE_EN;
  wire wr_flag     = wr_fire && w_be_reg && aw_addr_reg == ADDR_WAKE_FLAG;
  wire wr_mask     = wr_fire && w_be_reg && aw_addr_reg == ADDR_IRQ_MASK;
  wire wr_mapped   = aw_addr_reg == ADDR_STBY_CTRL
                  || aw_addr_reg == ADDR_DEEP_CTRL
                  || aw_addr_reg == ADDR_PROTECT
                  || aw_addr_reg == ADDR_WAKE_EDGE
                  || aw_addr_reg == ADDR_WAKE_EN
                  || aw_addr_reg == ADDR_WAKE_FLAG
                  || aw_addr_reg == ADDR_STATUS
                  || aw_addr_reg == ADDR_IRQ_STAT
                  || aw_addr_reg == ADDR_IRQ_MASK;
  wire rd_istat    = rd_fire && s_axi_araddr == ADDR_IRQ_STAT;

  // Read data mux
  logic [31:0] rd_data;
  logic        rd_ok;
  always_comb begin
    rd_ok   = 1'b1;
    rd_data = 32'h0000_0000;
    case (s_axi_araddr)
      ADDR_STBY_CTRL: rd_data[7:0] = standby_control_reg;
      ADDR_DEEP_CTRL: rd_data[7:0] = deep_standby_control_reg;
      ADDR_PROTECT:   rd_data[7:0] = write_protect_reg;
      ADDR_WAKE_EDGE: rd_data[7:0] = wake_edge_select_reg;
      ADDR_WAKE_EN:   rd_data[7:0] = wake_source_enable_reg;
      ADDR_WAKE_FLAG: rd_data[7:0] = wake_source_flag_reg;
      ADDR_STATUS:    rd_data[15:0] = {lat_cnt_reg, state_reg};
      ADDR_IRQ_STAT:  rd_data[3:0] = irq_stat_reg;
      ADDR_IRQ_MASK:  rd_data[3:0] = irq_mask_reg;
      default:        rd_ok = 1'b0;
    endcase
  end

  // ****************************************************
  // Mode decisions
  // ****************************************************
  wire sel_stby = standby_control_reg[STBY_SEL_BIT];
  wire sel_deep = deep_standby_control_reg[DEEP_SEL_BIT];
  wire [1:0] cut = deep_standby_control_reg[CUT_LO_BIT +: 2];
  wire refuse = large_s2_reg && (core_clock_src == SRC_MAIN
                              || core_clock_src == SRC_PLL);
  wire in_run = state_reg == ST_RUN;
  wire go_stby = in_run && wait_exec && sel_stby && !sel_deep && !refuse;
  wire go_deep = in_run && wait_exec && sel_stby && sel_deep && !refuse;
  wire ev_refuse = in_run && wait_exec && sel_stby && refuse;
  // Enabled edges on synchronised wake pins
  wire [7:0] rise = wake_s2_reg & ~wake_s3_reg;
  wire [7:0] fall = ~wake_s2_reg & wake_s3_reg;
  wire [7:0] edge_hit = wake_source_enable_reg
                      & ((wake_edge_select_reg & rise)
                      | (~wake_edge_select_reg & fall));
  wire sleeping = state_reg == ST_STBY || state_reg == ST_DEEP;
  wire wake_now = sleeping
               && |((wake_source_flag_reg | edge_hit)
                    & wake_source_enable_reg);
  wire lat_done = lat_cnt_reg == 12'h000;

  // Next state and latency count
  always_comb begin
    state_next   = state_reg;
    lat_cnt_next = lat_cnt_reg;
    case (state_reg)
      ST_RUN: begin
        if (go_deep) begin
          state_next = ST_DEEP;
        end else if (go_stby) begin
          state_next = ST_STBY;
        end
      end
      ST_STBY, ST_DEEP: begin
        if (wake_now) begin
          state_next   = ST_WAKE;
          lat_cnt_next = lat_cycles(state_reg == ST_DEEP, core_clock_div);
        end
      end
      ST_WAKE: begin
        if (lat_done) begin
          state_next = ST_RUN;
        end else begin
          lat_cnt_next = lat_cnt_reg - 12'h001;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  // ****************************************************
  // Domain enables
  // ****************************************************
  wire deep_now   = state_next == ST_DEEP;
  wire low_now    = state_next == ST_STBY || deep_now;
  wire ram_keep   = cut == CUT_NONE;
  wire det_keep   = cut != CUT_ALL;
  always_comb begin
    power_next.main_osc          = 1'b1;
    power_next.sub_osc           = 1'b1;
    power_next.rtc               = 1'b1;
    power_next.por               = !deep_now || det_keep;
    power_next.voltage_detector  = !deep_now || det_keep;
    power_next.usb_resume        = !deep_now || ram_keep;
    power_next.usb_core          = !low_now;
    power_next.cpu               = !low_now;
    power_next.fast_internal_osc = !low_now;
    power_next.slow_internal_osc = !low_now;
    power_next.watchdog_osc      = !deep_now;
    power_next.pll               = !low_now;
    power_next.flash             = !low_now;
    power_next.periph            = !low_now;
    power_next.bus_ctrl          = !low_now;
    power_next.ports             = !low_now;
    power_next.retained_ram_bank = !deep_now || ram_keep;
    power_next.volatile_ram_bank = !deep_now;
    power_next.pin_hold          = low_now
                        && deep_standby_control_reg[PIN_HOLD_BIT];
    power_next.bus_pin_output    = !low_now
                        || standby_control_reg[BUS_OE_BIT];
  end

  // ****************************************************
  // Synchronisers
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_s1_reg  <= 8'h00;
      wake_s2_reg  <= 8'h00;
      wake_s3_reg  <= 8'h00;
      large_s1_reg <= 1'b0;
      large_s2_reg <= 1'b0;
    end else if (ce) begin
      wake_s1_reg  <= wake_pin;
      wake_s2_reg  <= wake_s1_reg;
      wake_s3_reg  <= wake_s2_reg;
      large_s1_reg <= large_variant;
      large_s2_reg <= large_s1_reg;
    end
  end

  // ****************************************************
  // AXI4-Lite handshake
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 6'h00;
      w_data_reg    <= 8'h00;
      w_be_reg      <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[5:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_be_reg   <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Ready flags accept one item per channel until the answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready)
                    && !s_axi_bvalid;
      s_axi_wready  <= !w_have_reg && !(s_axi_wvalid && s_axi_wready)
                    && !s_axi_bvalid;
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
    end
  end

  // ****************************************************
  // Control registers
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      standby_control_reg      <= RST_STBY_CTRL;
      deep_standby_control_reg <= RST_DEEP_CTRL;
      write_protect_reg        <= RST_PROTECT;
      wake_edge_select_reg     <= RST_BYTE;
      wake_source_enable_reg   <= RST_BYTE;
    end else if (ce) begin
      if (wr_prot) begin
        write_protect_reg <= {6'h00, w_data_reg[1:0]};
      end
      if (wr_stby && mode_unlock) begin
        standby_control_reg <= w_data_reg & 8'h03;
      end
      if (wr_deep && mode_unlock) begin
        deep_standby_control_reg <= w_data_reg & 8'hC3;
      end
      if (wr_edge && mode_unlock) begin
        wake_edge_select_reg <= w_data_reg;
      end
      if (wr_en && mode_unlock) begin
        wake_source_enable_reg <= w_data_reg;
      end
    end
  end

  // ****************************************************
  // Sticky flags, sequencer, outputs
  // ****************************************************
  wire [3:0] ev = {state_reg == ST_WAKE && lat_done, ev_refuse,
                   go_deep, go_stby};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_source_flag_reg <= RST_BYTE;
      irq_stat_reg         <= 4'h0;
      irq_mask_reg         <= 4'h0;
      irq                  <= 1'b0;
      state_reg            <= ST_RUN;
      lat_cnt_reg          <= 12'h000;
      deep_standby_reset   <= 1'b0;
      power                <= '1;
    end else if (ce) begin
      // Set wins over the write-one clear
      wake_source_flag_reg <= (wake_source_flag_reg
                   & ~(wr_flag ? w_data_reg : 8'h00)) | edge_hit;
      irq_stat_reg <= (irq_stat_reg & ~{4{rd_istat}}) | ev;
      if (wr_mask) begin
        irq_mask_reg <= w_data_reg[3:0];
      end
      irq         <= |(((irq_stat_reg & ~{4{rd_istat}}) | ev)
                      & irq_mask_reg);
      state_reg   <= state_next;
      lat_cnt_reg <= lat_cnt_next;
      power       <= power_next;
      deep_standby_reset <= state_reg == ST_DEEP && wake_now;
    end
  end

endmodule

// [core/dsp_pkg.sv]
package dsp_pkg;

  // ****************************************************
  // Register map and field layout
  // ****************************************************
  localparam logic [5:0] ADDR_STBY_CTRL  = 6'h00;
  localparam logic [5:0] ADDR_DEEP_CTRL  = 6'h04;
  localparam logic [5:0] ADDR_PROTECT    = 6'h08;
  localparam logic [5:0] ADDR_WAKE_EDGE  = 6'h0C;
  localparam logic [5:0] ADDR_WAKE_EN    = 6'h10;
  localparam logic [5:0] ADDR_WAKE_FLAG  = 6'h14;
  localparam logic [5:0] ADDR_STATUS     = 6'h18;
  localparam logic [5:0] ADDR_IRQ_STAT   = 6'h1C;
  localparam logic [5:0] ADDR_IRQ_MASK   = 6'h20;

  localparam int STBY_SEL_BIT    = 0;
  localparam int BUS_OE_BIT      = 1;
  localparam int CUT_LO_BIT      = 0;
  localparam int PIN_HOLD_BIT    = 6;
  localparam int DEEP_SEL_BIT    = 7;
  localparam int UNLOCK_CLK_BIT  = 0;
  localparam int UNLOCK_MODE_BIT = 1;
  localparam logic [7:0] PROTECT_KEY = 8'hA5;

  localparam logic [7:0] RST_STBY_CTRL = 8'h00;
  localparam logic [7:0] RST_DEEP_CTRL = 8'h00;
  localparam logic [7:0] RST_PROTECT   = 8'h00;
  localparam logic [7:0] RST_BYTE      = 8'h00;

  // Event bits of the interrupt status register
  localparam int EV_STBY   = 0;
  localparam int EV_DEEP   = 1;
  localparam int EV_REFUSE = 2;
  localparam int EV_WAKE   = 3;

  // Power-cut field codes
  localparam logic [1:0] CUT_NONE    = 2'h0;
  localparam logic [1:0] CUT_ALL     = 2'h3;

  // Core clock source codes
  localparam logic [1:0] SRC_MAIN = 2'h0;
  localparam logic [1:0] SRC_PLL  = 2'h1;

  // Wake-up latency in cycles
  localparam logic [11:0] LAT_STBY_BASE = 12'h010;
  localparam logic [11:0] LAT_DEEP_BASE = 12'h080;
  localparam logic [11:0] LAT_CLK_STEP  = 12'h008;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [3:0] {
    ST_RUN  = 4'b0001,
    ST_STBY = 4'b0010,
    ST_DEEP = 4'b0100,
    ST_WAKE = 4'b1000
  } dsp_state_t;

  typedef struct packed {
    logic cpu;
    logic main_osc;
    logic sub_osc;
    logic fast_internal_osc;
    logic slow_internal_osc;
    logic watchdog_osc;
    logic pll;
    logic por;
    logic voltage_detector;
    logic rtc;
    logic usb_resume;
    logic usb_core;
    logic flash;
    logic periph;
    logic bus_ctrl;
    logic ports;
    logic retained_ram_bank;
    logic volatile_ram_bank;
    logic pin_hold;
    logic bus_pin_output;
  } dsp_power_t;

endpackage

// [sim/dsp_chk.sv]
`timescale 1ns/100ps
// ****************************************************
// Sequencer and register bus checks
// ****************************************************
module dsp_chk
  import dsp_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        wait_exec,
  input wire dsp_power_t  power,
  input wire logic        deep_standby_reset,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp
);
  // Deep standby as seen at the power outputs
  wire deep_on = !power.cpu && !power.volatile_ram_bank;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  entry_cause_a: assert property (
    $fell(power.cpu) |-> $past(wait_exec))
    else $error("core stopped without a wait request");
  keep_on_a: assert property (
    deep_on |-> power.main_osc && power.sub_osc && power.rtc)
    else $error("always-on unit stopped in deep standby");
  usb_core_a: assert property (
    deep_on |-> !power.usb_core)
    else $error("usb core running in deep standby");
  osc_stop_a: assert property (
    deep_on |-> !(power.fast_internal_osc || power.slow_internal_osc
                  || power.watchdog_osc || power.pll))
    else $error("internal oscillator running in deep standby");
  logic_stop_a: assert property (
    deep_on |-> !(power.flash || power.periph || power.bus_ctrl
                  || power.ports))
    else $error("flash, bus or port logic running in deep standby");
  exit_reset_a: assert property (
    deep_standby_reset |-> power.cpu && $past(deep_on))
    else $error("exit reset without deep standby or power restore");
  reset_pulse_a: assert property (
    deep_standby_reset |=> !deep_standby_reset)
    else $error("exit reset longer than one cycle");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accepted");
  resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before accepted");

  cover property (deep_standby_reset);
  cover property ($fell(power.cpu));
  cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind dsp_ctrl dsp_chk chk_u (.aclk, .aresetn, .wait_exec, .power,
  .deep_standby_reset, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);

// [sim/tb_deep_standby_power_controller.sv]
`timescale 1ns/100ps
module tb_deep_standby_power_controller
  import dsp_pkg::*;
();
  logic        aclk, aresetn, wait_exec, large_variant, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, deep_standby_reset;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [1:0]  bresp, rresp, rd_resp, wr_resp, core_clock_src, core_clock_div;
  logic [7:0]  wake_pin;
  dsp_power_t  power;
  int          num_errors, comparisons, cycles, resets_seen;
  int          n, n_s, n_d0, n_d1, lag;

  dsp_ctrl dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wait_exec(wait_exec),
    .core_clock_src(core_clock_src), .core_clock_div(core_clock_div),
    .large_variant(large_variant), .wake_pin(wake_pin), .power(power),
    .deep_standby_reset(deep_standby_reset), .irq(irq));

  // ****************************************************
  // Clock, watchdog and bus tasks
  // ****************************************************
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Cycle limit and exit reset counting
  always @(posedge aclk) begin
    cycles++;
    if (deep_standby_reset === 1'b1) resets_seen++;
    if (cycles == 30000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    // Slow master holds off the response handshake for lag cycles
    if (lag != 0) begin
      repeat (lag) @(posedge aclk);
      bready <= 1'b1;
      @(posedge aclk);
    end
    bready <= 1'b0;
    wr_resp = bresp;
  endtask

  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    // Slow master holds off the read handshake for lag cycles
    if (lag != 0) begin
      repeat (lag) @(posedge aclk);
      rready <= 1'b1;
      @(posedge aclk);
    end
    rready <= 1'b0;
    rd_val = rdata;
    rd_resp = rresp;
  endtask

  // Program the controller, then issue the wait request
  task automatic enter(input logic [7:0] sc, dc);
    wr(ADDR_PROTECT, 8'h03);
    wr(ADDR_STBY_CTRL, sc);
    wr(ADDR_DEEP_CTRL, dc);
    wr(ADDR_WAKE_EDGE, 8'h01);
    wr(ADDR_WAKE_EN, 8'h01);
    rd(ADDR_WAKE_EN);
    chk("wake enable", rd_val, 32'h1);
    wr(ADDR_WAKE_FLAG, 8'hFF);
    // No DMA or transfer engine sits on this bench: none to stop
    wr(ADDR_IRQ_MASK, 8'h08);
    rd(ADDR_IRQ_STAT);
    rd(ADDR_DEEP_CTRL);
    chk("deep control", rd_val, {24'h0, dc});
    @(posedge aclk);
    wait_exec <= 1'b1;
    @(posedge aclk);
    wait_exec <= 1'b0;
    @(posedge aclk);
  endtask

  // Raise wake pin, count cycles until the wake interrupt
  task automatic wake(output int c);
    wake_pin <= 8'h01;
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while (irq !== 1'b1);
    wake_pin <= 8'h00;
    rd(ADDR_IRQ_STAT);
    chk("wake event", {31'h0, rd_val[EV_WAKE]}, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask

  function automatic dsp_power_t deep_pwr(input logic [1:0] c, input logic h,
                                          input logic o);
    dsp_power_t p;
    p = '0;
    p.main_osc = 1'b1;
    p.sub_osc = 1'b1;
    p.rtc = 1'b1;
    p.por = (c != CUT_ALL);
    p.voltage_detector = (c != CUT_ALL);
    p.usb_resume = (c == CUT_NONE);
    p.retained_ram_bank = (c == CUT_NONE);
    p.pin_hold = h;
    p.bus_pin_output = o;
    return p;
  endfunction

  // ****************************************************
  // Test sequence
  // ****************************************************
  initial begin
    {aresetn, wait_exec, large_variant, awvalid, wvalid} = '0;
    {bready, arvalid, rready, awaddr, araddr, wdata, wake_pin} = '0;
    core_clock_div = 2'h0;
    core_clock_src = 2'h2;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset power", {12'h0, power}, 32'h000FFFFF);
    rd(6'h3C);
    chk("unmapped data", rd_val, 32'h0);
    chk("unmapped resp", {30'h0, rd_resp}, {30'h0, RESP_SLVERR});
    lag = 2;
    wr(ADDR_STBY_CTRL, 8'h01);
    chk("locked resp", {30'h0, wr_resp}, {30'h0, RESP_OKAY});
    rd(ADDR_STBY_CTRL);
    lag = 0;
    chk("locked write", rd_val, 32'h0);
    wr(6'h3C, 8'h00);
    chk("unmapped wr resp", {30'h0, wr_resp}, {30'h0, RESP_SLVERR});
    enter(8'h01, 8'h00);
    chk("standby power", {27'h0, power.cpu, power.main_osc, power.watchdog_osc,
        power.flash, power.volatile_ram_bank}, 32'h0D);
    rd(ADDR_STATUS);
    chk("standby state", {28'h0, rd_val[3:0]}, {28'h0, ST_STBY});
    wake(n_s);
    chk("standby exit reset", 32'(resets_seen), 32'h0);
    for (int i = 0; i < 4; i++) begin
      enter({6'h0, i[0], 1'b1}, {1'b1, i[1], 4'h0, i[1:0]});
      chk("deep power", {12'h0, power},
          {12'h0, deep_pwr(i[1:0], i[1], i[0])});
      rd(ADDR_STATUS);
      chk("deep state", {28'h0, rd_val[3:0]}, {28'h0, ST_DEEP});
      wake(n);
      chk("deep exit reset", 32'(resets_seen), 32'(i + 1));
      if (i == 0) n_d0 = n;
    end
    core_clock_div <= 2'h1;
    enter(8'h01, 8'h80);
    wake(n_d1);
    chk("divider latency", 32'(n_d1 - n_d0), 32'(LAT_CLK_STEP));
    chk("mode latency", 32'(n_d0 - n_s),
        32'(LAT_DEEP_BASE - LAT_STBY_BASE));
    large_variant <= 1'b1;
    core_clock_div <= 2'h0;
    for (int s = 0; s < 2; s++) begin
      core_clock_src <= s[1:0];
      enter(8'h01, 8'h80);
      chk("refused power", {12'h0, power}, 32'h000FFFFD);
      chk("masked irq", {31'h0, irq}, 32'h0);
      rd(ADDR_IRQ_STAT);
      chk("refused event", rd_val, 32'h4);
    end
    core_clock_src <= 2'h2;
    enter(8'h01, 8'h80);
    chk("safe source entry", {31'h0, power.cpu}, 32'h0);
    wake(n);
    complete_run();
  end
endmodule
